// ---- hdl/dioc_top.sv ----
// Dual interrupt output control: latched status, two enable registers, two pads.
// Assumes detector levels arrive asynchronously and software uses AHB-Lite.
//
// Notes on behaviour
// - PLL flag set when unlocked while powered.
// - PLL flag held until status read.
// - Positive drive detail after 128ms fault.
// - Negative drive detail after 128ms fault.
// - Four DC detail bits, bits three to zero.
// - DC details active with DC flag.
// - Each pin ORs its own enabled flags.
// - Enable bits 23..8 select same status bits.
// - Enables cleared at reset.
// - Both pins active low.
// - Primary pad type from low bits, reset 11.
// - Secondary pad type likewise, reset 11.
// - Open-drain allows wired-OR sharing.
// - Status read clears latched flags.
//
// The AHB-Lite register port was left to the implementer.

`timescale 1ns/100ps

module dioc_top
#(
  parameter int unsigned P_DRIVE_HOLD_CYC = dioc_pkg::DRIVE_HOLD_CYC
)
(
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // AHB-Lite slave port.
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Detector levels.
  input wire logic [15:0] i_evt_raw,
  input wire logic i_pll_locked,
  input wire logic i_chan_active,
  input wire logic i_current_drive_pos,
  input wire logic i_current_drive_neg,
  input wire logic i_dc_detect_en,
  input wire logic [3:0] i_dc_level,
  // Primary interrupt pad.
  output logic o_irq_out_primary_n,
  output logic o_irq_out_primary_oe,
  output logic o_irq_out_primary_pu,
  // Secondary interrupt pad.
  output logic o_irq_out_secondary_n,
  output logic o_irq_out_secondary_oe,
  output logic o_irq_out_secondary_pu,
  // Summary interrupt.
  output logic o_irq
);

  // ----------------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------------
  logic [24:0] sync_meta;
  logic [24:0] sync_q;
  wire [24:0] async_in = {i_evt_raw, i_pll_locked, i_chan_active, i_current_drive_pos,
                          i_current_drive_neg, i_dc_detect_en, i_dc_level};

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sync_meta <= 25'h0000000;
      sync_q <= 25'h0000000;
    end
    else
    begin
      sync_meta <= async_in;
      sync_q <= sync_meta;
    end
  end

  wire [15:0] evt_s = sync_q[24:9];
  wire pll_locked_s = sync_q[8];
  wire chan_active_s = sync_q[7];
  wire [1:0] drive_fault_s = sync_q[6:5];
  wire dc_en_s = sync_q[4];
  wire [3:0] dc_level_s = sync_q[3:0];

  // ----------------------------------------------------------------
  // Drive generator persistence timers.
  // ----------------------------------------------------------------
  localparam logic [23:0] DRIVE_LIM = 24'(P_DRIVE_HOLD_CYC);
  logic [23:0] drive_cnt [2];
  logic [1:0] drive_det;

  for (genvar g = 0; g < 2; g++)
  begin : g_drive
    assign drive_det[g] = (drive_cnt[g] == DRIVE_LIM);

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
      if (!i_rst_b)
      begin
        drive_cnt[g] <= 24'h000000;
      end
      else if (!drive_fault_s[g])
      begin
        drive_cnt[g] <= 24'h000000;
      end
      else if (!drive_det[g])
      begin
        drive_cnt[g] <= drive_cnt[g] + 24'h000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status conditions and latched flags.
  // ----------------------------------------------------------------
  wire pll_cond = chan_active_s & ~pll_locked_s;
  wire [3:0] dc_det = dc_level_s & {4{dc_en_s}};
  wire dc_flag = |dc_det;
  wire drive_sum = |drive_det;
  wire [23:0] cond = {evt_s[15:13], dc_flag, evt_s[11:8], drive_sum, 3'h0,
                      evt_s[3:1], pll_cond, 2'h0, drive_det, dc_det} & dioc_pkg::STATUS_IMPL;

  logic [23:0] status;
  logic [23:0] en_pri;
  logic [23:0] en_sec;
  logic [23:0] irq_mask;
  logic [7:0] rd_idx;
  logic rd_take;
  logic wr_en;
  logic [7:0] wr_idx;
  logic [23:0] wr_data;

  wire rd_status = rd_take & (rd_idx == dioc_pkg::STATUS_IDX);
  wire [23:0] next_status = (status & ~{24{rd_status}}) | cond;

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      status <= dioc_pkg::STATUS_RESET;
    end
    else
    begin
      status <= next_status;
    end
  end

  // ----------------------------------------------------------------
  // Register file.
  // ----------------------------------------------------------------
  wire wr_pri = wr_en & (wr_idx == dioc_pkg::PRI_EN_IDX);
  wire wr_sec = wr_en & (wr_idx == dioc_pkg::SEC_EN_IDX);
  wire wr_mask = wr_en & (wr_idx == dioc_pkg::IRQ_MASK_IDX);
  wire [23:0] rd_word = (rd_idx == dioc_pkg::STATUS_IDX) ? status :
                        (rd_idx == dioc_pkg::PRI_EN_IDX) ? en_pri :
                        (rd_idx == dioc_pkg::SEC_EN_IDX) ? en_sec :
                        (rd_idx == dioc_pkg::IRQ_MASK_IDX) ? irq_mask : 24'h000000;

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      en_pri <= dioc_pkg::ENABLE_RESET;
      en_sec <= dioc_pkg::ENABLE_RESET;
      irq_mask <= dioc_pkg::MASK_RESET;
    end
    else
    begin
      if (wr_pri)
      begin
        en_pri <= wr_data & dioc_pkg::ENABLE_WMASK;
      end
      if (wr_sec)
      begin
        en_sec <= wr_data & dioc_pkg::ENABLE_WMASK;
      end
      if (wr_mask)
      begin
        irq_mask <= wr_data & dioc_pkg::STATUS_IMPL;
      end
    end
  end

  dioc_ahb_slave u_bus
  (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hsize(i_hsize),
    .i_hwdata(i_hwdata),
    .i_hready(i_hready),
    .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_rd_idx(rd_idx),
    .i_rd_word(rd_word),
    .o_rd_take(rd_take),
    .o_wr_en(wr_en),
    .o_wr_idx(wr_idx),
    .o_wr_data(wr_data)
  );

  // ----------------------------------------------------------------
  // Interrupt OR terms and pads.
  // ----------------------------------------------------------------
  wire pri_assert = |(status[23:8] & en_pri[23:8]);
  wire sec_assert = |(status[23:8] & en_sec[23:8]);

  dioc_pad_drv u_pad_pri
  (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_assert(pri_assert),
    .i_type(en_pri[1:0]),
    .o_pin_n(o_irq_out_primary_n),
    .o_oe(o_irq_out_primary_oe),
    .o_pullup(o_irq_out_primary_pu)
  );

  dioc_pad_drv u_pad_sec
  (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_assert(sec_assert),
    .i_type(en_sec[1:0]),
    .o_pin_n(o_irq_out_secondary_n),
    .o_oe(o_irq_out_secondary_oe),
    .o_pullup(o_irq_out_secondary_pu)
  );

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_irq <= 1'b0;
    end
    else
    begin
      o_irq <= |(status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_status_read;
    rd_status ##0 !pll_cond;
  endsequence

  sequence s_pri_armed;
    (en_pri[1:0] == 2'b01) && pri_assert;
  endsequence

  sequence s_drive_held;
    drive_det[1] || drive_det[0];
  endsequence

  a_pll_flag_set: assert property ((chan_active_s && !pll_locked_s) |=> status[8])
    else $error("pll flag not set while unlocked");
  a_pll_flag_hold: assert property ((status[8] && !rd_status) |=> status[8])
    else $error("pll flag dropped without status read");
  a_drive_pos_time: assert property ($rose(drive_det[1]) |-> ($past(drive_cnt[1]) == DRIVE_LIM - 24'h000001))
    else $error("positive drive detail timing wrong");
  a_drive_neg_time: assert property ($rose(status[4]) |-> $past(drive_det[0]) && $past(drive_fault_s[0], 2))
    else $error("negative drive detail without persistent fault");
  a_dc_detail_map: assert property ((dc_en_s && dc_level_s[3]) |=> (status[3] && status[20]))
    else $error("dc detail not reported with dc flag");
  a_enable_reset: assert property ($past(!i_rst_b) |-> (en_pri == 24'h000003 && en_sec == 24'h000003))
    else $error("enable registers not at reset value");
  a_read_clears: assert property (s_status_read ##0 !pll_cond |=> !status[8] || pll_cond)
    else $error("status read did not clear pll flag");
  a_enable_next_cycle: assert property (s_pri_armed |=> (!o_irq_out_primary_n && o_irq_out_primary_oe))
    else $error("primary pin did not follow enabled flags");
  a_secondary_idle: assert property ((en_sec[1:0] == 2'b01 && !sec_assert) |=> o_irq_out_secondary_n)
    else $error("secondary pin asserted with no enabled flag");
  a_drive_pos_status: assert property (drive_det[1] |=> (status[5] && status[15]))
    else $error("positive drive detail not latched");
  a_drive_neg_status: assert property (drive_det[0] |=> (status[4] && status[15]))
    else $error("negative drive detail not latched");
  a_drive_summary: assert property (s_drive_held |=> status[15])
    else $error("drive summary flag not set");
  a_pri_masked: assert property ((en_pri[1:0] == 2'b01 && !pri_assert) |=> o_irq_out_primary_n)
    else $error("primary pin asserted with no enabled flag");
  a_irq_level_set: assert property ((|(status & irq_mask)) |=> o_irq)
    else $error("summary interrupt not raised");
  a_irq_level_clear: assert property (!(|(status & irq_mask)) |=> !o_irq)
    else $error("summary interrupt raised with no unmasked flag");

endmodule

// ---- shared/dioc_pkg.sv ----
// Constants and types shared by the dual interrupt output control block.
// Assumes a single 125 MHz reference clock and word-aligned register access.

package dioc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing.
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned DRIVE_HOLD_MS = 128;
  localparam int unsigned DRIVE_HOLD_CYC = (DRIVE_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DRIVE_CNT_W = 24;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index.
  // ----------------------------------------------------------------
  localparam int unsigned IDX_W = 8;
  localparam logic [7:0] STATUS_IDX = 8'h01;
  localparam logic [7:0] PRI_EN_IDX = 8'h02;
  localparam logic [7:0] SEC_EN_IDX = 8'h03;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h06;

  // ----------------------------------------------------------------
  // Field layout.
  // ----------------------------------------------------------------
  localparam int unsigned REG_W = 24;
  localparam int unsigned ENABLE_LSB = 8;
  localparam int unsigned PAD_TYPE_LSB = 0;
  localparam int unsigned PLL_BIT = 8;
  localparam int unsigned DRIVE_SUM_BIT = 15;
  localparam int unsigned DC_FLAG_BIT = 20;
  localparam int unsigned DRIVE_POS_BIT = 5;
  localparam int unsigned DC_POS_HIGH_BIT = 3;
  localparam logic [23:0] STATUS_IMPL = 24'hff8f3f;
  localparam logic [23:0] ENABLE_WMASK = 24'hff8f03;

  // ----------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------
  localparam logic [23:0] STATUS_RESET = 24'h000000;
  localparam logic [23:0] ENABLE_RESET = 24'h000003;
  localparam logic [23:0] MASK_RESET = 24'h000000;

  // ----------------------------------------------------------------
  // Interrupt pad types.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PAD_OFF = 2'b00,
    PAD_PUSH = 2'b01,
    PAD_OD = 2'b10,
    PAD_OD_PU = 2'b11
  } dioc_pad_e;

endpackage

// ---- hdl/dioc_ahb_slave.sv ----
// AHB-Lite slave front end of the interrupt control registers.
// Assumes single word transfers; reads take no wait state, writes one.

`timescale 1ns/100ps

module dioc_ahb_slave
(
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // AHB-Lite slave port.
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Register file side.
  output logic [7:0] o_rd_idx,
  input wire logic [23:0] i_rd_word,
  output logic o_rd_take,
  output logic o_wr_en,
  output logic [7:0] o_wr_idx,
  output logic [23:0] o_wr_data
);

  logic wr_pend;
  logic [7:0] wr_idx;
  wire take = i_hsel & i_htrans[1] & i_hready;
  wire wr_take = take & i_hwrite;

  assign o_rd_idx = i_haddr[9:2];
  assign o_rd_take = take & ~i_hwrite;
  assign o_wr_en = wr_pend;
  assign o_wr_idx = wr_idx;
  assign o_wr_data = i_hwdata[23:0];

  // ----------------------------------------------------------------
  // Transfer tracking.
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_hrdata <= 32'h00000000;
    end
    else
    begin
      wr_pend <= wr_take;
      o_hreadyout <= ~wr_take;
      o_hresp <= 1'b0;
      if (wr_take)
      begin
        wr_idx <= i_haddr[9:2];
      end
      if (o_rd_take)
      begin
        o_hrdata <= {8'h00, i_rd_word};
      end
    end
  end

endmodule

// ---- hdl/dioc_pad_drv.sv ----
// Registered driver for one active-low interrupt pad.
// Assumes the pad cell resolves the wire from output, enable and pull-up.

`timescale 1ns/100ps

module dioc_pad_drv
(
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Request and pad type.
  input wire logic i_assert,
  input wire logic [1:0] i_type,
  // Pad controls.
  output logic o_pin_n,
  output logic o_oe,
  output logic o_pullup
);

  logic next_pin_n;
  logic next_oe;
  dioc_pkg::dioc_pad_e pad_type;

  assign pad_type = dioc_pkg::dioc_pad_e'(i_type);

  always_comb
  begin
    next_pin_n = 1'b1;
    next_oe = 1'b0;
    unique case (pad_type)
      dioc_pkg::PAD_OFF:
      begin
        next_pin_n = 1'b1;
        next_oe = 1'b0;
      end
      dioc_pkg::PAD_PUSH:
      begin
        next_pin_n = ~i_assert;
        next_oe = 1'b1;
      end
      dioc_pkg::PAD_OD, dioc_pkg::PAD_OD_PU:
      begin
        next_pin_n = 1'b0;
        next_oe = i_assert;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_pin_n <= 1'b1;
      o_oe <= 1'b0;
      o_pullup <= 1'b1;
    end
    else
    begin
      o_pin_n <= next_pin_n;
      o_oe <= next_oe;
      o_pullup <= (pad_type == dioc_pkg::PAD_OD_PU);
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  a_pad_push_pull: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_type == 2'b01) |=> (o_oe && (o_pin_n == !$past(i_assert))))
    else $error("push-pull pad level wrong");
  a_pad_open_drain: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_type[1] && !i_assert) |=> (!o_oe && (o_pullup == $past(i_type[0]))))
    else $error("open-drain pad driven while idle");
  a_pad_disabled: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_type == 2'b00) |=> (!o_oe && !o_pullup))
    else $error("disabled pad still driven");

endmodule

// ---- tb/dioc_host_line.sv ----
// Host-side model of one interrupt line: the pad, a board pull-up and another device.
// Assumes the pad controls come straight from a design pad driver.

`timescale 1ns/100ps

module dioc_host_line
(
  // Clock.
  input wire logic i_ref_clk,
  // Pad controls.
  input wire logic i_pin_n,
  input wire logic i_oe,
  input wire logic i_pullup,
  // Board side.
  input wire logic i_other_low_n,
  input wire logic i_board_pullup,
  // Level seen by the host.
  output logic o_line
);
  logic float_q = 1'b0;
  wire logic pulled_low = (i_oe && !i_pin_n) || !i_other_low_n;
  wire logic held_high = (i_oe && i_pin_n) || i_pullup || i_board_pullup;
  always @(posedge i_ref_clk)
  begin
    float_q <= !float_q;
  end
  // A released line with no pull-up wanders, so a stale level never passes.
  assign o_line = pulled_low ? 1'b0 : (held_high ? 1'b1 : float_q);
endmodule

// ---- tb/test_dual_interrupt_output_control.sv ----
// Self-checking bench of the dual interrupt output control block.
// Assumes the package, the design files and the host line model are compiled first.

`timescale 1ns/100ps

module test_dual_interrupt_output_control;
  typedef struct packed {logic [23:0] en; logic [15:0] evt; logic [4:0] dcl;
    logic [1:0] drv; logic [23:0] st; logic n;} dioc_row_s;
  localparam logic [31:0] addr_st = {22'h0, dioc_pkg::STATUS_IDX, 2'b00};
  localparam logic [31:0] addr_pri = {22'h0, dioc_pkg::PRI_EN_IDX, 2'b00};
  localparam logic [31:0] addr_sec = {22'h0, dioc_pkg::SEC_EN_IDX, 2'b00};
  localparam logic [31:0] addr_msk = {22'h0, dioc_pkg::IRQ_MASK_IDX, 2'b00};
  localparam logic [2:0] pad_exp [4] = '{3'b010, 3'b100, 3'b100, 3'b101};
  logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, locked = 1'b1, chan = 1'b0;
  logic dpos = 1'b0, dneg = 1'b0, dc_en = 1'b0, other_n = 1'b1, resp_q;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd_q;
  logic [15:0] evt = 16'h0;
  logic [3:0] dc_lvl = 4'h0;
  wire logic [31:0] hrdata;
  wire logic hready, hresp, p_n, p_oe, p_pu, s_n, s_oe, s_pu, irq, p_line, s_line;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  dioc_row_s rows [12] = '{
    '{24'h800001, 16'h8000, 5'h00, 2'b00, 24'h800000, 1'b0}, '{24'h400001, 16'h8000, 5'h00, 2'b00, 24'h800000, 1'b1},
    '{24'h000201, 16'h0002, 5'h00, 2'b00, 24'h000200, 1'b0}, '{24'h7f0e01, 16'h0001, 5'h00, 2'b00, 24'h000000, 1'b1},
    '{24'h000001, 16'hffff, 5'h00, 2'b00, 24'hef0e00, 1'b1}, '{24'h100001, 16'h0000, 5'h18, 2'b00, 24'h100008, 1'b0},
    '{24'h100001, 16'h0000, 5'h14, 2'b00, 24'h100004, 1'b0}, '{24'h100001, 16'h0000, 5'h12, 2'b00, 24'h100002, 1'b0},
    '{24'h100001, 16'h0000, 5'h11, 2'b00, 24'h100001, 1'b0}, '{24'h100001, 16'h0000, 5'h08, 2'b00, 24'h000000, 1'b1},
    '{24'h008001, 16'h0000, 5'h00, 2'b10, 24'h008020, 1'b0}, '{24'h008001, 16'h0000, 5'h00, 2'b01, 24'h008010, 1'b0}};

  dioc_top #(.P_DRIVE_HOLD_CYC(8)) dut_u
  (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .i_evt_raw(evt), .i_pll_locked(locked), .i_chan_active(chan), .i_current_drive_pos(dpos),
    .i_current_drive_neg(dneg), .i_dc_detect_en(dc_en), .i_dc_level(dc_lvl), .o_irq_out_primary_n(p_n),
    .o_irq_out_primary_oe(p_oe), .o_irq_out_primary_pu(p_pu), .o_irq_out_secondary_n(s_n),
    .o_irq_out_secondary_oe(s_oe), .o_irq_out_secondary_pu(s_pu), .o_irq(irq)
  );
  dioc_host_line host_p_u
  (
    .i_ref_clk(clk), .i_pin_n(p_n), .i_oe(p_oe), .i_pullup(p_pu), .i_other_low_n(other_n),
    .i_board_pullup(1'b1), .o_line(p_line)
  );
  dioc_host_line host_s_u
  (
    .i_ref_clk(clk), .i_pin_n(s_n), .i_oe(s_oe), .i_pullup(s_pu), .i_other_low_n(1'b1),
    .i_board_pullup(1'b0), .o_line(s_line)
  );

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks.
  // ----------------------------------------------------------------
  initial
  begin
    forever #4 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("Counts: %0d checks, %0d mismatches", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      tally_and_finish;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic is_wr, input logic [31:0] addr, input logic [31:0] wdata);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= is_wr;
    haddr <= addr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wdata;
    do @(posedge clk); while (hready !== 1'b1);
    rd_q = hrdata;
    resp_q = hresp;
  endtask
  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    bus(1'b1, addr, data);
  endtask
  task automatic chk_rd(input string name, input logic [31:0] addr, input logic [31:0] exp);
    bus(1'b0, addr, 32'h0);
    check(name, rd_q, exp);
    check("bus response", {31'h0, resp_q}, 32'h0);
  endtask
  task automatic set_det(input logic [15:0] e, input logic [4:0] d, input logic [1:0] v);
    @(posedge clk);
    evt <= e;
    dc_en <= d[4];
    dc_lvl <= d[3:0];
    dpos <= v[1];
    dneg <= v[0];
  endtask

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial
  begin
    tick(20);
    rst_b <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      wr(addr_pri, {8'h0, rows[i].en});
      set_det(rows[i].evt, rows[i].dcl, rows[i].drv);
      tick(24);
      check("primary line", {31'h0, p_line}, {31'h0, rows[i].n});
      set_det(16'h0, 5'h0, 2'b00);
      tick(8);
      chk_rd("status latched", addr_st, {8'h0, rows[i].st});
      chk_rd("status cleared", addr_st, 32'h0);
      $display("Row %0d done", i);
    end
    @(posedge clk);
    rst_b <= 1'b0;
    tick(20);
    check("pad oe in reset", {30'h0, p_oe, s_oe}, 32'h0);
    check("pad pull-up in reset", {30'h0, p_pu, s_pu}, 32'h3);
    rst_b <= 1'b1;
    chk_rd("primary enable reset", addr_pri, 32'h3);
    chk_rd("secondary enable reset", addr_sec, 32'h3);
    chk_rd("mask reset", addr_msk, 32'h0);
    wr(addr_st, 32'hffffff);
    wr(32'h40, 32'hffffff);
    chk_rd("unmapped read", 32'h40, 32'h0);
    chk_rd("status read-only", addr_st, 32'h0);
    set_det(16'h0, 5'h0, 2'b11);
    tick(4);
    set_det(16'h0, 5'h0, 2'b00);
    tick(8);
    chk_rd("short drive fault", addr_st, 32'h0);
    $display("Reset and short fault test done");
    @(posedge clk);
    locked <= 1'b0;
    tick(8);
    chk_rd("pll unpowered", addr_st, 32'h0);
    wr(addr_pri, 32'h000101);
    wr(addr_msk, 32'h000100);
    @(posedge clk);
    chan <= 1'b1;
    tick(8);
    check("pll line", {31'h0, p_line}, 32'h0);
    check("irq raised", {31'h0, irq}, 32'h1);
    wr(addr_msk, 32'h0);
    tick(3);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(addr_pri, 32'h000001);
    tick(2);
    check("pll masked", {31'h0, p_line}, 32'h1);
    @(posedge clk);
    locked <= 1'b1;
    wr(addr_msk, 32'h000100);
    tick(8);
    chk_rd("pll latched", addr_st, 32'h100);
    tick(3);
    check("irq cleared", {31'h0, irq}, 32'h0);
    chk_rd("pll cleared", addr_st, 32'h0);
    $display("Pll and irq test done");
    set_det(16'h0002, 5'h0, 2'b00);
    for (int t = 0; t < 4; t++)
    begin
      wr(addr_pri, 32'h200 | t);
      wr(addr_sec, 32'h200 | t);
      tick(4);
      check("primary pad", {29'h0, p_oe, p_n, p_pu}, {29'h0, pad_exp[t]});
      check("secondary pad", {29'h0, s_oe, s_n, s_pu}, {29'h0, pad_exp[t]});
      if (t > 0)
        check("secondary line", {31'h0, s_line}, 32'h0);
    end
    set_det(16'h0, 5'h0, 2'b00);
    tick(8);
    chk_rd("sync flag", addr_st, 32'h200);
    wr(addr_sec, 32'h000201);
    tick(2);
    check("secondary idle", {31'h0, s_line}, 32'h1);
    wr(addr_pri, 32'h000002);
    @(posedge clk);
    other_n <= 1'b0;
    tick(2);
    check("shared line low", {30'h0, p_oe, p_line}, 32'h0);
    other_n <= 1'b1;
    tick(2);
    check("shared line released", {30'h0, p_oe, p_line}, 32'h1);
    $display("Pad type and sharing test done");
    tally_and_finish;
  end
endmodule
